/* File: dv/iioc_host.sv */
// Host model: issues port read and write cycles to the control block.
// Assumes one clock; it drives just after a rising edge.
`timescale 1ns/1ns
module iioc_host (
   // Clock
   input  wire logic        mclk,
   // Host I/O cycle
   output logic      [15:0] io_addr,
   output logic             io_rd,
   output logic             io_wr,
   output logic      [7:0]  io_wdata,
   input  wire logic [7:0]  io_rdata,
   input  wire logic        io_rvalid
);
   // ==========================================================
   // Idle bus; released lines show the inverse of their last value
   initial begin
      io_addr  = 16'h0000;
      io_rd    = 1'b0;
      io_wr    = 1'b0;
      io_wdata = 8'h00;
   end
   // One write strobe, taken at the next edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'b1;
      @(posedge mclk);
      io_wr    <= 1'b0;
      io_addr  <= ~a;
      io_wdata <= ~d;
   endtask
   // Read strobe; data must be valid the cycle after it is taken
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      io_addr <= a;
      io_rd   <= 1'b1;
      @(posedge mclk);
      io_rd   <= 1'b0;
      io_addr <= ~a;
      #1;
      d = io_rvalid ? io_rdata : 8'hxx;
   endtask
endmodule // iioc_host

/* File: dv/testbench.sv */
// Self-checking bench for the industrial I/O control register.
// Assumes the host model drives the port cycles.
`timescale 1ns/1ns
module testbench;
   import iioc_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        alt_addr_sel = 1'b0;
   logic [15:0] io_addr;
   logic        io_rd;
   logic        io_wr;
   logic [7:0]  io_wdata;
   logic [7:0]  io_rdata;
   logic        io_rvalid;
   logic [1:0]  c5;
   logic        c4;
   logic [3:0]  dir;
   logic        busy;
   logic [7:0]  rv;
   int          err_count = 0;
   int          comparisons = 0;
   int          n;
   // Rows: bit 8 alternate block, bits 7:0 written value
   logic [8:0]  rows [5] = '{9'h07f, 9'h025, 9'h15a, 9'h10c, 9'h000};
   always #5 mclk = ~mclk;
   iioc_ctrl #(.CONV_CYC(16)) dut (.mclk(mclk), .rst(rst),
      .alt_addr_sel(alt_addr_sel), .io_addr(io_addr), .io_rd(io_rd),
      .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid), .counter5_clock_select(c5),
      .counter4_clock_select(c4), .port_group_direction(dir),
      .conversion_busy(busy));
   iioc_host host (.mclk(mclk), .io_addr(io_addr), .io_rd(io_rd),
      .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid));
   // ==========================================================
   // Checking and closing
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Start a conversion, then follow busy and the done bit
   task automatic convert(input logic [6:0] sel);
      host.wr(IIOC_ADDR_RES_LO, 8'h18);
      n = 0;
      while (busy !== 1'b1 && n < 400) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk("acq", 8'h01, 8'(n == int'(IIOC_ACQ_CYC) + 1));
      host.rd(IIOC_ADDR_CTRL, rv);
      chk("done_busy", {1'b0, sel}, rv);
      n = 0;
      while (busy !== 1'b0 && n < 40) begin
         @(posedge mclk);
         #1;
         n++;
      end
      host.rd(IIOC_ADDR_CTRL, rv);
      chk("done_set", {1'b1, sel}, rv);
   endtask
   // Watchdog well beyond the expected 1500 cycles
   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge mclk);
      chk("rst_out", 8'h00, {busy, c5, c4, dir});
      rst <= 1'b0;
      // Table rows; done bit written as 1 must not stick
      foreach (rows[i]) begin
         @(posedge mclk);
         alt_addr_sel <= rows[i][8];
         host.wr(rows[i][8] ? IIOC_ADDR_CTRL_ALT : IIOC_ADDR_CTRL,
                 rows[i][7:0] | 8'h80);
         host.wr(rows[i][8] ? IIOC_ADDR_CTRL : IIOC_ADDR_CTRL_ALT,
                 ~rows[i][7:0]);
         #1;
         chk("selects", {1'b0, rows[i][6:0]}, {1'b0, c5, c4, dir});
         host.rd(rows[i][8] ? IIOC_ADDR_CTRL_ALT : IIOC_ADDR_CTRL, rv);
         chk("readback", {1'b0, rows[i][6:0]}, rv);
         host.rd(rows[i][8] ? IIOC_ADDR_CTRL : IIOC_ADDR_CTRL_ALT, rv);
         chk("unmapped", 8'h00, rv);
      end
      $display("Test table done");
      // Done cleared by reading the high result
      host.wr(IIOC_ADDR_CTRL, 8'h35);
      convert(7'h35);
      host.rd(IIOC_ADDR_RES_HI, rv);
      host.rd(IIOC_ADDR_CTRL, rv);
      chk("clr_hi", 8'h35, rv);
      // Control write keeps done; low result read clears it
      convert(7'h35);
      host.wr(IIOC_ADDR_CTRL, 8'h0a);
      host.rd(IIOC_ADDR_CTRL, rv);
      chk("keep_done", 8'h8a, rv);
      host.rd(IIOC_ADDR_RES_LO, rv);
      host.rd(IIOC_ADDR_CTRL, rv);
      chk("clr_lo", 8'h0a, rv);
      // A new start clears done at once
      convert(7'h0a);
      host.wr(IIOC_ADDR_RES_LO, 8'h18);
      host.rd(IIOC_ADDR_CTRL, rv);
      chk("clr_start", 8'h0a, rv);
      $display("Test conversion done");
      // Reset in mid-acquisition
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk("rst_mid", 8'h00, {busy, c5, c4, dir});
      @(posedge mclk);
      rst <= 1'b0;
      // The cut acquisition must not turn into a conversion
      repeat (2) @(posedge mclk);
      #1;
      chk("rst_rel", 8'h00, {busy, c5, c4, dir});
      host.rd(IIOC_ADDR_CTRL, rv);
      chk("rst_rd", 8'h00, rv);
      repeat (330) @(posedge mclk);
      #1;
      chk("no_conv", 8'h00, {7'h00, busy});
      $display("Test reset done");
      report_and_stop();
   end
endmodule // testbench

/* File: src/iioc_acq_if.sv */
// Interface between control block and acquisition timer.
// Assumes both ends share mclk.
`timescale 1ns/1ns
interface iioc_acq_if;
   logic start;   // One-cycle start of acquisition
   logic conv;    // One-cycle start of conversion
   modport ctl (output start, input conv);
   modport tmr (input start, output conv);
endinterface

/* File: src/iioc_acq_timer.sv */
// Internally timed acquisition interval before each conversion.
// Assumes start is a one-cycle pulse synchronous to mclk.
`timescale 1ns/1ns
module iioc_acq_timer
   import iioc_pkg::*;
(
   // Clock and reset
   input  wire logic   mclk,
   input  wire logic   rst,
   // Handshake with control block
   iioc_acq_if.tmr     acq
);
   typedef struct packed {
      logic [9:0] cnt;
      logic       busy;
      logic       conv;
      logic [9:0] age;    // Cycles since start, for the length check
   } iioc_tmr_s;
   iioc_tmr_s st_r, st_nxt;

   // ==========================================================
   // Count down the acquisition window, restart on new start
   always_comb begin
      st_nxt      = st_r;
      st_nxt.conv = 1'b0;
      if (acq.start) begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt  = IIOC_ACQ_CYC - 10'd1;
         st_nxt.age  = 10'd0;
      end else if (st_r.busy) begin
         st_nxt.age = st_r.age + 10'd1;
         if (st_r.cnt == 10'd0) begin
            st_nxt.busy = 1'b0;
            st_nxt.conv = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt - 10'd1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) st_r <= '0;
      else     st_r <= st_nxt;
   end
   assign acq.conv = st_r.conv;

   // ==========================================================
   // Interval counted apart from cnt, so a wrong reload shows up
   property p_acq_len;
      @(posedge mclk) disable iff (rst)
      st_r.conv |-> st_r.age == IIOC_ACQ_CYC;
   endproperty
   a_acq_len: assert property (p_acq_len)
      else $error("Acquisition interval length wrong");
endmodule // iioc_acq_timer

/* File: src/iioc_ctrl.sv */
// Industrial I/O control register with conversion-complete status.
// Assumes a synchronous I/O cycle: io_rd/io_wr are one-cycle strobes
// with io_addr valid; read data is registered, valid the next cycle.
//
// Summary of operation
// - Decode register at 1D3h, or 1E3h when the alternate setup is chosen.
// - Done bit reads 0 while a conversion runs.
// - Done bit sets to 1 when a conversion finishes.
// - Done bit clears when a new conversion begins.
// - Done clears on reading either result register or writing conversion control.
// - Bits 6-5 pick counter 5 clock: oscillator, counter 4, external.
// - Bit 4 picks counter 4 clock: oscillator or external input.
// - Bit 3 makes lines 31..24 outputs when set.
// - Bit 2 makes lines 23..16 outputs when set.
// - Bit 1 makes lines 15..8 outputs when set.
// - Bit 0 makes lines 7..0 outputs when set.
// - Writing conversion control starts six-clock acquisition, then convert.
`timescale 1ns/1ns
module iioc_ctrl
   import iioc_pkg::*;
#(
   parameter int CONV_CYC = 16   // Converter busy time in mclk cycles
)(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Setup strap: alternate address block
   input  wire logic        alt_addr_sel,
   // Host I/O cycle
   input  wire logic [15:0] io_addr,
   input  wire logic        io_rd,
   input  wire logic        io_wr,
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  io_rdata,
   output logic             io_rvalid,
   // Counter clock selects
   output logic      [1:0]  counter5_clock_select,
   output logic             counter4_clock_select,
   // Port group directions, bit n is group n
   output logic      [3:0]  port_group_direction,
   // Converter status
   output logic             conversion_busy
);
   typedef struct packed {
      logic [6:0] ctrl;     // Writable bits 6..0
      logic       done;
      logic       conv;
      logic [9:0] ccnt;
      logic [9:0] age;      // Cycles since last start, saturating
      logic [7:0] rdata;
      logic       rvalid;
   } iioc_ctrl_s;
   iioc_ctrl_s st_r, st_nxt;

   iioc_acq_if acq ();
   logic [15:0] base_ofs;
   logic        hit_ctrl, hit_lo, hit_hi, hit_conv;
   logic [15:0] conv_addr;

   iioc_acq_timer u_acq (
      .mclk (mclk),
      .rst  (rst),
      .acq  (acq.tmr)
   );

   // ==========================================================
   // Address decode; alternate setup shifts the whole block
   assign base_ofs = alt_addr_sel ? IIOC_ADDR_ALT_OFS : 16'h0000;
   assign conv_addr = IIOC_ADDR_RES_LO + base_ofs;
   assign hit_ctrl = io_addr ==
      (alt_addr_sel ? IIOC_ADDR_CTRL_ALT : IIOC_ADDR_CTRL);
   assign hit_lo   = io_addr == IIOC_ADDR_RES_LO + base_ofs;
   assign hit_hi   = io_addr == IIOC_ADDR_RES_HI + base_ofs;
   assign hit_conv = io_addr == conv_addr;
   assign acq.start = io_wr && hit_conv;

   // ==========================================================
   // Register, status and converter model
   always_comb begin
      st_nxt        = st_r;
      st_nxt.rvalid = io_rd;
      st_nxt.rdata  = 8'h00;
      // Age of the last start, read only by the interval check below
      if (acq.start)
         st_nxt.age = 10'd0;
      else if (st_r.age != 10'h3ff)
         st_nxt.age = st_r.age + 10'd1;
      if (io_wr && hit_ctrl)
         st_nxt.ctrl = io_wdata[6:0];            // done ignored
      if ((io_rd && (hit_lo || hit_hi)) || (io_wr && hit_conv))
         st_nxt.done = 1'b0;
      if (acq.conv) begin
         st_nxt.conv = 1'b1;
         st_nxt.done = 1'b0;
         st_nxt.ccnt = 10'(CONV_CYC - 1);
      end else if (st_r.conv) begin
         if (st_r.ccnt == 10'd0) begin
            st_nxt.conv = 1'b0;
            st_nxt.done = 1'b1;                  // set wins
         end else begin
            st_nxt.ccnt = st_r.ccnt - 10'd1;
         end
      end
      if (io_rd && hit_ctrl)
         st_nxt.rdata = {st_r.done && !st_r.conv, st_r.ctrl};
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r      <= '0;
         st_r.ctrl <= IIOC_CTRL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs straight from the state register
   assign io_rdata  = st_r.rdata;
   assign io_rvalid = st_r.rvalid;
   assign counter5_clock_select =
      st_r.ctrl[IIOC_BIT_C5HI:IIOC_BIT_C5LO];
   assign counter4_clock_select = st_r.ctrl[IIOC_BIT_C4];
   assign port_group_direction  =
      st_r.ctrl[IIOC_BIT_GRP3:IIOC_BIT_GRP0];
   assign conversion_busy = st_r.conv;

   // ==========================================================
   property p_dec_wr;
      @(posedge mclk) disable iff (rst)
      io_wr && io_addr == (alt_addr_sel ? IIOC_ADDR_CTRL_ALT
                                        : IIOC_ADDR_CTRL)
      |=> port_group_direction == $past(io_wdata[3:0]);
   endproperty
   a_dec_wr: assert property (p_dec_wr)
      else $error("Control write not decoded");

   property p_busy_rd;
      @(posedge mclk) disable iff (rst)
      io_rd && hit_ctrl && st_r.conv |=> io_rdata[IIOC_BIT_DONE] == 1'b0;
   endproperty
   a_busy_rd: assert property (p_busy_rd)
      else $error("Done read 1 during conversion");

   property p_done_set;
      @(posedge mclk) disable iff (rst)
      $fell(st_r.conv) |-> st_r.done;
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("Done not set at end of conversion");

   property p_start_clr;
      @(posedge mclk) disable iff (rst)
      acq.conv |=> !st_r.done && st_r.conv;
   endproperty
   a_start_clr: assert property (p_start_clr)
      else $error("Done not cleared at conversion start");

   property p_rd_clr;
      @(posedge mclk) disable iff (rst)
      io_rd && (hit_lo || hit_hi) && !(st_r.conv && st_r.ccnt == 10'd0)
      |=> !st_r.done;
   endproperty
   a_rd_clr: assert property (p_rd_clr)
      else $error("Result read did not clear done");

   property p_c5;
      @(posedge mclk) disable iff (rst)
      io_wr && hit_ctrl ##1 (!(io_wr && hit_ctrl))[*3]
      |-> counter5_clock_select == $past(io_wdata[6:5], 3);
   endproperty
   a_c5: assert property (p_c5)
      else $error("Counter 5 select not held");

   property p_c4;
      @(posedge mclk) disable iff (rst)
      io_wr && hit_ctrl |=> counter4_clock_select == $past(io_wdata[4]);
   endproperty
   a_c4: assert property (p_c4)
      else $error("Counter 4 select wrong");

   property p_dir;
      @(posedge mclk) disable iff (rst)
      !(io_wr && hit_ctrl) |=> $stable(port_group_direction);
   endproperty
   a_dir: assert property (p_dir)
      else $error("Direction changed without write");

   property p_done_wr;
      @(posedge mclk) disable iff (rst)
      io_wr && hit_ctrl && !hit_conv && !acq.conv && !st_r.conv
      |=> st_r.done == $past(st_r.done);
   endproperty
   a_done_wr: assert property (p_done_wr)
      else $error("Write changed done bit");

   // Start is seen on the same edge as the timer, busy one edge after the timer's pulse
   property p_conv_after_acq;
      @(posedge mclk) disable iff (rst)
      $rose(st_r.conv) |-> st_r.age == IIOC_ACQ_CYC + 10'd1;
   endproperty
   a_conv_after_acq: assert property (p_conv_after_acq)
      else $error("Conversion did not follow acquisition");

   property p_rd_ans;
      @(posedge mclk) disable iff (rst)
      io_rd |=> io_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("Read not answered next cycle");

   property p_rd_unmap;
      @(posedge mclk) disable iff (rst)
      io_rd && !hit_ctrl |=> io_rdata == 8'h00;
   endproperty
   a_rd_unmap: assert property (p_rd_unmap)
      else $error("Unmapped read returned data");

   c_conv:  cover property (@(posedge mclk) disable iff (rst)
                            $fell(st_r.conv));
   c_rdone: cover property (@(posedge mclk) disable iff (rst)
                            io_rvalid && io_rdata[IIOC_BIT_DONE]);
   c_alt:   cover property (@(posedge mclk) disable iff (rst)
                            alt_addr_sel && io_wr && hit_ctrl);
   c_restart: cover property (@(posedge mclk) disable iff (rst)
                              st_r.done && io_wr && hit_conv);
endmodule // iioc_ctrl

/* File: src/iioc_pkg.sv */
// Package for the industrial I/O control register block.
// Assumes an ISA-style I/O cycle: 16-bit port address, 8-bit data.
package iioc_pkg;
   // ==========================================================
   // Port addresses
   localparam logic [15:0] IIOC_ADDR_CTRL     = 16'h01D3;
   localparam logic [15:0] IIOC_ADDR_CTRL_ALT = 16'h01E3;
   localparam logic [15:0] IIOC_ADDR_RES_LO   = 16'h01D8;
   localparam logic [15:0] IIOC_ADDR_RES_HI   = 16'h01D9;
   localparam logic [15:0] IIOC_ADDR_ALT_OFS  = 16'h0010;
   // ==========================================================
   // Field positions of the control register
   localparam int IIOC_BIT_DONE  = 7;
   localparam int IIOC_BIT_C5HI  = 6;
   localparam int IIOC_BIT_C5LO  = 5;
   localparam int IIOC_BIT_C4    = 4;
   localparam int IIOC_BIT_GRP3  = 3;
   localparam int IIOC_BIT_GRP0  = 0;
   // Value after reset of the writable bits (none printed)
   localparam logic [6:0] IIOC_CTRL_RST = 7'h00;
   // ==========================================================
   // Counter clock source codes
   localparam logic [1:0] IIOC_C5_OSC   = 2'h0;
   localparam logic [1:0] IIOC_C5_CNT4  = 2'h1;
   localparam logic [1:0] IIOC_C5_EXT   = 2'h2;
   // ==========================================================
   // Acquisition timing: six clocks of a converter clock
   localparam int IIOC_ACQ_CLOCKS = 6;
   localparam int IIOC_ACQ_TIME_NS = 3260;   // 3.26 us
   localparam int IIOC_CLK_NS     = 10;
   localparam logic [9:0] IIOC_ACQ_CYC =
      10'((IIOC_ACQ_TIME_NS + IIOC_CLK_NS - 1) / IIOC_CLK_NS);
endpackage
